// >>> rtl/ara_pkg.sv
// Functional notes
// - Single conversion: 12-bit result every conversion
// - Justify bit picks bits 11:0 or 15:4
// - Unused result bits always read zero
// - Repeat above one: sum, update at end
// - Accumulate 4, 8 or 16 samples right-justified
// - Repeat field bits 2:1 select 1/4/8/16
// - Done and window events once per series
// - Burst: one start runs whole series
// - SAR period is divider plus one
// - Subsystem clock follows burst enable selection
// - Conversion takes 13 SAR plus 2 cycles
package ara_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ARA_CFG_ADDR      = 8'hbc;
  localparam logic [7:0] ARA_CFG_RESET     = 8'hf8;
  localparam int         ARA_CFG_DIV_LSB   = 3;
  localparam int         ARA_CFG_DIV_W     = 5;
  localparam int         ARA_CFG_RPT_LSB   = 1;
  localparam int         ARA_CFG_GAIN_BIT  = 0;
  localparam logic [7:0] ARA_UNMAPPED_READ = 8'h00;

  // ----------------------------------------------------------------
  // Conversion timing
  // ----------------------------------------------------------------
  localparam int         ARA_SAMPLE_W      = 12;
  localparam logic [3:0] ARA_SAR_CYCLES    = 4'hd;
  localparam int         ARA_SUBSYSTEM_CLOCK_EXTRA    = 2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ARA_IDLE,
    ARA_START,
    ARA_CONV,
    ARA_FINISH,
    ARA_WAIT
  } ara_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic [7:0] wdata;
  } ara_sfr_req_t;

  typedef struct packed {
    logic       conv_done;
    logic       window_evt;
    logic       busy;
    logic       sar_clk;
  } ara_status_t;

endpackage : ara_pkg

// >>> rtl/ara_accum.sv
`timescale 1ns/100ps
module ara_accum
  import ara_pkg::*;
(
  // Clock and reset
  input  wire logic                    core_clk_i,
  input  wire logic                    sys_rst_i,
  // Special function register port
  input  wire ara_sfr_req_t            sfr_req_i,
  output logic [7:0]                   sfr_rdata_o,
  // Converter control
  input  wire logic                    conv_start_i,
  input  wire logic                    justify_select_bit_i,
  input  wire logic                    burst_enable_i,
  // Analog front end
  input  wire logic [ARA_SAMPLE_W-1:0] sample_i,
  // Results and status
  output logic [7:0]                   result_high_byte_o,
  output logic [7:0]                   result_low_byte_o,
  output logic                         gain_enable_bit_o,
  output ara_status_t                  status_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    ara_state_t                st;
    logic [7:0]                cfg;
    logic [ARA_CFG_DIV_W-1:0]  div_cnt;
    logic [3:0]                bit_cnt;
    logic [4:0]                rpt_left;
    logic [15:0]               acc;
    logic [15:0]               result;
    logic [7:0]                rdata;
    logic [ARA_SAMPLE_W-1:0]   samp_meta;
    logic [ARA_SAMPLE_W-1:0]   samp_sync;
    ara_status_t               stat;
  } ara_regs_t;

  ara_regs_t state_reg;
  ara_regs_t state_next;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Series length from the repeat field
  function automatic logic [4:0] ara_series_len(input logic [1:0] rpt);
    case (rpt)
      2'b00:   ara_series_len = 5'h01;
      2'b01:   ara_series_len = 5'h04;
      2'b10:   ara_series_len = 5'h08;
      default: ara_series_len = 5'h10;
    endcase
  endfunction : ara_series_len

  // Only the configuration register is mapped; other addresses read zero
  function automatic logic ara_cfg_hit(input logic [7:0] addr);
    ara_cfg_hit = (addr == ARA_CFG_ADDR);
  endfunction : ara_cfg_hit

  // Zero-extends one sample to the width of the result pair
  function automatic logic [15:0] ara_widen(input logic [ARA_SAMPLE_W-1:0] smp);
    ara_widen = {4'h0, smp};
  endfunction : ara_widen

  // Single conversions follow the justify bit; the free nibble stays zero
  function automatic logic [15:0] ara_justify(input logic [ARA_SAMPLE_W-1:0] smp,
                                              input logic                    left);
    if (left) begin
      ara_justify = {smp, 4'h0};
    end else begin
      ara_justify = {4'h0, smp};
    end
  endfunction : ara_justify

  // Approximation clock is high for the first half of each period. The
  // compare runs one bit wider: divider 31 plus one would wrap to zero.
  function automatic logic ara_sar_high(input logic [ARA_CFG_DIV_W-1:0] cnt,
                                        input logic [ARA_CFG_DIV_W-1:0] div);
    logic [ARA_CFG_DIV_W:0] cnt_inc;
    logic [ARA_CFG_DIV_W:0] half;
    cnt_inc      = {1'b0, cnt} + 6'h01;
    half         = ({1'b0, div} + 6'h01) >> 1;
    ara_sar_high = cnt_inc < half;
  endfunction : ara_sar_high

  logic [1:0]               rpt_sel;
  logic [ARA_CFG_DIV_W-1:0] div_sel;

  assign rpt_sel = state_reg.cfg[ARA_CFG_RPT_LSB +: 2];
  assign div_sel = state_reg.cfg[ARA_CFG_DIV_LSB +: ARA_CFG_DIV_W];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next                 = state_reg;
    state_next.stat.conv_done  = 1'b0;
    state_next.stat.window_evt = 1'b0;

    // Sample word is settled long before it is taken; two stages keep the
    // analog side out of the logic anyway.
    state_next.samp_meta = sample_i;
    state_next.samp_sync = state_reg.samp_meta;

    if (sfr_req_i.wr && ara_cfg_hit(sfr_req_i.addr)) begin
      state_next.cfg = sfr_req_i.wdata;
    end
    if (ara_cfg_hit(sfr_req_i.addr)) begin
      state_next.rdata = state_reg.cfg;
    end else begin
      state_next.rdata = ARA_UNMAPPED_READ;
    end

    case (state_reg.st)
      ARA_IDLE: begin
        state_next.stat.busy = 1'b0;
        // A start while a conversion runs is ignored, not queued; in ARA_WAIT it starts the next one
        if (conv_start_i) begin
          state_next.acc       = 16'h0000;
          state_next.rpt_left  = ara_series_len(rpt_sel);
          state_next.st        = ARA_START;
          state_next.stat.busy = 1'b1;
        end
      end
      ARA_START: begin
        // First of the two extra subsystem cycles
        state_next.div_cnt      = '0;
        state_next.bit_cnt      = 4'h0;
        state_next.stat.sar_clk = 1'b1;
        state_next.st           = ARA_CONV;
      end
      ARA_CONV: begin
        // SAR period is (divider + 1) subsystem cycles
        if (state_reg.div_cnt == div_sel) begin
          state_next.div_cnt      = '0;
          state_next.stat.sar_clk = 1'b1;
          state_next.bit_cnt      = state_reg.bit_cnt + 4'h1;
          if (state_reg.bit_cnt == ARA_SAR_CYCLES - 4'h1) begin
            state_next.stat.sar_clk = 1'b0;
            state_next.st           = ARA_FINISH;
          end
        end else begin
          state_next.div_cnt      = state_reg.div_cnt + 1'b1;
          state_next.stat.sar_clk = ara_sar_high(state_reg.div_cnt, div_sel);
        end
      end
      ARA_FINISH: begin
        // Second extra subsystem cycle: take the sample
        state_next.acc      = state_reg.acc + ara_widen(state_reg.samp_sync);
        state_next.rpt_left = state_reg.rpt_left - 5'h01;
        if (state_reg.rpt_left == 5'h01) begin
          if (rpt_sel == 2'b00) begin
            state_next.result = ara_justify(state_reg.samp_sync, justify_select_bit_i);
          end else begin
            // Justify bit is ignored while repeating; software keeps it clear
            state_next.result = state_reg.acc + ara_widen(state_reg.samp_sync);
          end
          state_next.stat.conv_done  = 1'b1;
          state_next.stat.window_evt = 1'b1;
          state_next.stat.busy       = 1'b0;
          state_next.st              = ARA_IDLE;
        end else if (burst_enable_i) begin
          state_next.st = ARA_START;
        end else begin
          state_next.st = ARA_WAIT;
        end
      end
      ARA_WAIT: begin
        // Each further conversion needs its own start outside burst mode
        if (conv_start_i) begin
          state_next.st = ARA_START;
        end
      end
      default: begin
        state_next.st = ARA_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // core_clk_i is the subsystem clock; the burst/system selection happens
  // in the clock mux ahead of this block, steered by burst_enable_i
  // Reset drops any series in flight; results read zero again
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      state_reg     <= '0;
      state_reg.st  <= ARA_IDLE;
      state_reg.cfg <= ARA_CFG_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign sfr_rdata_o        = state_reg.rdata;
  assign result_high_byte_o = state_reg.result[15:8];
  assign result_low_byte_o  = state_reg.result[7:0];
  assign gain_enable_bit_o  = state_reg.cfg[ARA_CFG_GAIN_BIT];
  assign status_o           = state_reg.stat;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Sixteen summed samples need four bits of headroom in the pair
  if (ARA_SAMPLE_W + 4 != 16) begin : g_bad_sample_w
    $error("ara_accum: sample width does not fit the result pair");
  end
  // Divider field must fill the top of the configuration byte
  if (ARA_CFG_DIV_LSB + ARA_CFG_DIV_W != 8) begin : g_bad_div_field
    $error("ara_accum: divider field leaves the configuration byte");
  end
  // Repeat field sits below the divider, clear of the gain bit
  if (ARA_CFG_RPT_LSB + 2 != ARA_CFG_DIV_LSB || ARA_CFG_GAIN_BIT >= ARA_CFG_RPT_LSB) begin : g_bad_rpt_field
    $error("ara_accum: repeat field overlaps its neighbours");
  end

endmodule : ara_accum

// >>> test/ara_accum_checker.sv
`timescale 1ns/100ps
module ara_accum_checker
  import ara_pkg::*;
(
  // Clock, reset and register port
  input wire logic                    core_clk_i,
  input wire logic                    sys_rst_i,
  input wire ara_sfr_req_t            sfr_req_i,
  input wire logic [7:0]              sfr_rdata_o,
  // Conversion side
  input wire logic                    conv_start_i,
  input wire logic                    justify_select_bit_i,
  input wire logic                    burst_enable_i,
  input wire logic [ARA_SAMPLE_W-1:0] sample_i,
  input wire logic [7:0]              result_high_byte_o,
  input wire logic [7:0]              result_low_byte_o,
  input wire logic                    gain_enable_bit_o,
  input wire ara_status_t             status_o
);
  // Shadow copy of the configuration, so checks can follow the repeat field
  logic [7:0] cfg_q;
  logic       one_done;
  assign one_done = status_o.conv_done && cfg_q[2:1] == 2'b00;
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) cfg_q <= ARA_CFG_RESET;
    else if (sfr_req_i.wr && sfr_req_i.addr == ARA_CFG_ADDR) cfg_q <= sfr_req_i.wdata;
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  AST_DONE_WIN: assert property (status_o.conv_done == status_o.window_evt) else $error("event skew");
  AST_DONE_ONE: assert property (status_o.conv_done |=> !status_o.conv_done) else $error("long done");
  AST_RES_HOLD: assert property (!status_o.conv_done |-> $stable({result_high_byte_o, result_low_byte_o}))
    else $error("early result");
  AST_RIGHT: assert property (one_done && !justify_select_bit_i |-> result_high_byte_o[7:4] == 4'h0)
    else $error("high bits");
  AST_LEFT: assert property (one_done && justify_select_bit_i |-> result_low_byte_o[3:0] == 4'h0)
    else $error("low bits");
  AST_CONV_LEN: assert property ($rose(status_o.busy) && cfg_q[7:1] == 7'h00 |-> ##15 status_o.conv_done)
    else $error("length");
  AST_SAR_IDLE: assert property (!status_o.busy |-> !status_o.sar_clk) else $error("sar clock idle");
  AST_START: assert property (conv_start_i && !status_o.busy |=> status_o.busy) else $error("start lost");
  AST_RD_NONE: assert property (sfr_req_i.addr != ARA_CFG_ADDR |=> sfr_rdata_o == 8'h00) else $error("unmapped");
  AST_RD_CFG: assert property (sfr_req_i.addr == ARA_CFG_ADDR |=> sfr_rdata_o == $past(cfg_q)) else $error("cfg");
  AST_GAIN: assert property (gain_enable_bit_o == cfg_q[0]) else $error("gain");
  cover property (status_o.conv_done && cfg_q[2:1] == 2'b11);
  cover property (one_done && justify_select_bit_i);
  cover property (sfr_req_i.wr && sfr_req_i.addr == ARA_CFG_ADDR);
endmodule : ara_accum_checker
bind ara_accum ara_accum_checker ara_accum_checker_i (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
  .sfr_req_i(sfr_req_i), .sfr_rdata_o(sfr_rdata_o), .conv_start_i(conv_start_i), .sample_i(sample_i),
  .justify_select_bit_i(justify_select_bit_i), .burst_enable_i(burst_enable_i), .status_o(status_o),
  .result_high_byte_o(result_high_byte_o), .result_low_byte_o(result_low_byte_o),
  .gain_enable_bit_o(gain_enable_bit_o));

// >>> test/ara_testbench.sv
`timescale 1ns/100ps
module testbench;
  import ara_pkg::*;
  logic         core_clk_i, sys_rst_i, conv_start_i, justify_select_bit_i, burst_enable_i, gain_enable_bit_o;
  logic [7:0]   sfr_rdata_o, result_high_byte_o, result_low_byte_o, rd;
  logic [11:0]  sample_i;
  ara_sfr_req_t sfr_req_i;
  ara_status_t  status_o;
  int           fails, compares, n, hi;
  ara_accum ara_accum_i (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .sfr_req_i(sfr_req_i),
    .sfr_rdata_o(sfr_rdata_o), .conv_start_i(conv_start_i), .justify_select_bit_i(justify_select_bit_i),
    .burst_enable_i(burst_enable_i), .sample_i(sample_i), .result_high_byte_o(result_high_byte_o),
    .result_low_byte_o(result_low_byte_o), .gain_enable_bit_o(gain_enable_bit_o), .status_o(status_o));
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic finish_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    sfr_req_i <= '{addr: a, wr: 1'b1, wdata: d};
    @(posedge core_clk_i);
    sfr_req_i <= '{addr: a, wr: 1'b0, wdata: d};
    @(posedge core_clk_i);
  endtask : sfr_wr
  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
    sfr_req_i <= '{addr: a, wr: 1'b0, wdata: 8'h00};
    repeat (2) @(posedge core_clk_i);
    d = sfr_rdata_o;
  endtask : sfr_rd
  // Waits on the falling edge so the done pulse is read once it has settled
  task automatic series(input int starts, input logic bst, input logic jst, input logic [11:0] smp,
                        input logic [15:0] exp);
    int n;
    burst_enable_i <= bst;
    justify_select_bit_i <= jst;
    sample_i <= smp;
    for (int i = 0; i < starts; i++) begin
      conv_start_i <= 1'b1;
      @(posedge core_clk_i);
      conv_start_i <= 1'b0;
      for (n = 0; n < 300 && status_o.conv_done !== 1'b1; n++) @(negedge core_clk_i);
      check("done", 16'(i == starts - 1), 16'(n < 300));
      @(posedge core_clk_i);
    end
    check("result", exp, {result_high_byte_o, result_low_byte_o});
    $display("test %h done", exp);
  endtask : series
  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  initial begin
    #50000;
    fails++;
    finish_test();
  end
  initial begin
    sys_rst_i <= 1'b1;
    sfr_req_i <= '0;
    {conv_start_i, justify_select_bit_i, burst_enable_i} <= 3'h0;
    sample_i <= 12'h000;
    repeat (6) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    sfr_rd(8'hbc, rd);
    check("cfg reset", 16'h00f8, {8'h00, rd});
    sfr_rd(8'hbd, rd);
    check("unmapped", 16'h0000, {8'h00, rd});
    sfr_wr(8'hbc, 8'h01);
    sfr_rd(8'hbc, rd);
    check("cfg gain", 16'h0101, {rd, 7'h00, gain_enable_bit_o});
    $display("test registers done");
    // Same sample in every repeat setting, so each sum is a plain shift
    for (int r = 0; r < 4; r++) begin
      sfr_wr(8'hbc, {5'h00, 2'(r), 1'b0});
      series(1, 1'b1, 1'b0, 12'hfff, 16'h0fff << (r == 0 ? 0 : r + 1));
    end
    sfr_wr(8'hbc, 8'h00);
    series(1, 1'b0, 1'b1, 12'h7ff, 16'h7ff0);
    sfr_wr(8'hbc, 8'h02);
    series(4, 1'b0, 1'b0, 12'h800, 16'h2000);
    // Divider 1 doubles each approximation period
    sfr_wr(8'hbc, 8'h08);
    hi = 0;
    conv_start_i <= 1'b1;
    @(posedge core_clk_i);
    conv_start_i <= 1'b0;
    for (n = 0; n < 300 && status_o.conv_done !== 1'b1; n++) begin
      @(negedge core_clk_i);
      if (status_o.sar_clk === 1'b1) hi++;
    end
    check("cycles", 16'(int'(ARA_SAR_CYCLES) * 2 + ARA_SUBSYSTEM_CLOCK_EXTRA + 1), 16'(n));
    check("sar highs", 16'(int'(ARA_SAR_CYCLES)), 16'(hi));
    check("result", 16'h0800, {result_high_byte_o, result_low_byte_o});
    $display("test divider done");
    finish_test();
  end
endmodule : testbench
